/* File: link_regs_pkg.sv */
// Package for the port link control and status dword.
// Holds the register offset, field positions, reset values and sequence counts.
// Assumes the configuration port presents byte addresses of a 4 KB space.
package link_regs_pkg;

   // ==========================================================================
   // Register placement
   // ==========================================================================
   localparam int CFG_ADDR_W = 12;
   localparam logic [11:0] LINK_REG_OFFSET = 12'h0d0;

   // ==========================================================================
   // Control half, bits 15:0
   // ==========================================================================
   localparam int ASPM_LSB = 0;
   localparam int RCB_BIT = 3;
   localparam int LINK_DIS_BIT = 4;
   localparam int RETRAIN_BIT = 5;
   localparam int COMMON_CLK_BIT = 6;
   localparam int EXT_SYNC_BIT = 7;
   localparam int CLK_PM_BIT = 8;
   localparam int HW_WIDTH_DIS_BIT = 9;
   localparam int BW_MGMT_IE_BIT = 10;
   localparam int AUTO_BW_IE_BIT = 11;

   localparam logic [1:0] ASPM_DISABLED = 2'h0;
   localparam logic [1:0] ASPM_L0S_ONLY = 2'h1;
   localparam logic [1:0] ASPM_L1_ONLY = 2'h2;
   localparam logic [1:0] ASPM_BOTH = 2'h3;
   localparam logic [1:0] ASPM_RESET = 2'h0;

   // ==========================================================================
   // Status half, bits 31:16
   // ==========================================================================
   localparam int SPEED_LSB = 16;
   localparam int WIDTH_LSB = 20;
   localparam int TRAIN_ERR_BIT = 26;
   localparam int TRAINING_BIT = 27;
   localparam int SLOT_CLK_BIT = 28;
   localparam int DL_ACTIVE_BIT = 29;
   localparam int BW_MGMT_ST_BIT = 30;
   localparam int AUTO_BW_ST_BIT = 31;

   localparam logic [3:0] SPEED_2G5 = 4'h1;
   localparam logic [3:0] SPEED_5G0 = 4'h2;
   localparam logic [3:0] SPEED_RESET = 4'h2;
   localparam logic [5:0] WIDTH_RESET = 6'h01;
   localparam logic TRAINING_RESET = 1'b1;
   localparam logic SLOT_CLK_RESET = 1'b1;

   // ==========================================================================
   // Ordered-set counts on exit to L0
   // ==========================================================================
   localparam int OS_CNT_W = 13;
   localparam logic [12:0] EXT_FTS_COUNT = 13'h1000;
   localparam logic [12:0] EXT_TS1_COUNT = 13'h0400;
   localparam logic [12:0] DEF_FTS_COUNT = 13'h0020;
   localparam logic [12:0] DEF_TS1_COUNT = 13'h0010;

endpackage

/* File: exit_seq_if.sv */
// Interface between the register block and the exit ordered-set sequencer.
// Assumes both ends run on the configuration clock.
`timescale 1ns/1ns
`default_nettype none
interface exit_seq_if;
   logic req;
   logic from_l1;
   logic ext_sync;
   logic os_ready;
   logic os_valid;
   logic os_is_ts1;
   logic done;
   logic busy;

   modport ctrl (output req, output from_l1, output ext_sync, output os_ready,
                 input os_valid, input os_is_ts1, input done, input busy);
   modport seq (input req, input from_l1, input ext_sync, input os_ready,
                output os_valid, output os_is_ts1, output done, output busy);
endinterface
`default_nettype wire

/* File: exit_sequencer.sv */
// Sequencer that counts the ordered sets sent when the link leaves L0s or L1.
// Assumes the transmitter accepts one ordered set per cycle with valid and ready.
`timescale 1ns/1ns
`default_nettype none
module exit_sequencer
   import link_regs_pkg::*;
#(
   parameter logic [12:0] N_FTS = DEF_FTS_COUNT,
   parameter logic [12:0] N_TS1 = DEF_TS1_COUNT
) (
   input wire logic core_clk, // Configuration clock.
   input wire logic rst,      // Synchronous reset, active high.
   exit_seq_if.seq sq         // Request and ordered-set handshake.
);

   if (N_FTS == 13'h0000 || N_TS1 == 13'h0000) begin : g_chk
      $error("exit_sequencer: ordered-set counts must be at least one");
   end

   typedef enum logic [0:0] {IDLE, SEND} seq_state_e;

   seq_state_e state, next_state;
   logic [12:0] remain, next_remain;
   logic is_ts1, next_is_ts1;
   logic done_q, next_done_q;

   // ==========================================================================
   // Next-state logic
   // ==========================================================================
   always_comb begin
      next_state = state;
      next_remain = remain;
      next_is_ts1 = is_ts1;
      next_done_q = 1'b0;
      case (state)
         IDLE: begin
            // Requests while a sequence runs are dropped; the link cannot be in two exits.
            if (sq.req) begin
               next_is_ts1 = sq.from_l1;
               if (sq.ext_sync) begin
                  next_remain = sq.from_l1 ? EXT_TS1_COUNT : EXT_FTS_COUNT; // [R07]
               end else begin
                  next_remain = sq.from_l1 ? N_TS1 : N_FTS;
               end
               next_state = SEND;
            end
         end
         SEND: begin
            if (sq.os_ready) begin
               next_remain = remain - 13'h0001;
               if (remain == 13'h0001) begin
                  next_state = IDLE;
                  next_done_q = 1'b1;
               end
            end
         end
         default: begin
            next_state = IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= IDLE;
         remain <= 13'h0000;
         is_ts1 <= 1'b0;
         done_q <= 1'b0;
      end else begin
         state <= next_state;
         remain <= next_remain;
         is_ts1 <= next_is_ts1;
         done_q <= next_done_q;
      end
   end

   assign sq.os_valid = (state == SEND);
   assign sq.busy = (state == SEND);
   assign sq.os_is_ts1 = is_ts1;
   assign sq.done = done_q;

endmodule
`default_nettype wire

/* File: link_ctrl_status.sv */
// Link control and link status register pair of one switch port, sharing one dword.
// Assumes the configuration port and the link training logic run on core_clk;
// only the open-drain clock request pin arrives from outside and is synchronised.
//
// Behaviour
// [R01] The two-bit power-state entry field decodes 00 none, 01 L0s, 10 L1, 11 both, and resets to 00.
// [R02] The receive side may always enter L0s, whatever the power-state entry field holds.
// [R03] The read completion boundary bit 3 is read-only and always reads zero.
// [R04] Link disable bit 4 is fixed at zero on the upstream port and disables the link on a downstream port.
// [R05] Writing one to retrain bit 5 on a downstream port starts retraining, and the bit always reads zero.
// [R06] Common clock bit 6 stores what is written, resets to zero, and reports a shared reference clock.
// [R07] With extended sync set, 4096 FTS sets leave L0s and 1024 TS1 sets leave L1; the bit resets to zero.
// [R08] With clock power management bit 8 clear the clock request pin is held low; downstream fixes it at zero.
// [R09] The two bandwidth interrupt enables, bits 10 and 11, are read-only upstream and writable downstream.
// [R10] The negotiated speed reads 0001 for 2.5 Gb/s or 0010 for 5.0 Gb/s and resets to 0010.
// [R11] The negotiated lane count sits in bits 25 to 20 and reads one lane after reset.
// [R12] Training error bit 26 sets on a failed training and clears when the link reaches L0.
// [R13] Training bit 27 is one while training runs, clears at completion, and resets to one.
// [R14] Slot clock bit 28 is read-only, resets to one, and may be reloaded from the loader.
// [R15] Bit 29 is one while the data link state machine is in DL_Active and resets to zero.
// [R16] Bandwidth status bits 30 and 31 set on their events and clear when software writes one.
`timescale 1ns/1ns
`default_nettype none
module link_ctrl_status
   import link_regs_pkg::*;
#(
   parameter bit UPSTREAM_PORT = 1'b0,      // One for the upstream port of the switch.
   parameter logic [12:0] N_FTS = DEF_FTS_COUNT, // FTS sets on L0s exit without extended sync.
   parameter logic [12:0] N_TS1 = DEF_TS1_COUNT  // TS1 sets on L1 exit without extended sync.
) (
   input wire logic core_clk,          // Configuration clock, 20 MHz.
   input wire logic rst,               // Synchronous reset, active high.
   input wire logic cfg_req,           // Configuration access request.
   input wire logic cfg_wr,            // One for a write, zero for a read.
   input wire logic [11:0] cfg_addr,   // Byte address of the dword.
   input wire logic [3:0] cfg_be,      // Byte enables.
   input wire logic [31:0] cfg_wdata,  // Write data.
   output logic cfg_ack,               // One-cycle answer to every request.
   output logic [31:0] cfg_rdata,      // Read data, valid with cfg_ack.
   input wire logic lt_start,          // Training has started.
   input wire logic lt_done,           // Training reached L0.
   input wire logic lt_fail,           // Training failed.
   input wire logic [3:0] neg_speed,   // Negotiated speed, taken at lt_done.
   input wire logic [5:0] neg_width,   // Negotiated lanes, taken at lt_done.
   input wire logic dl_active,         // Data link state machine in DL_Active.
   input wire logic bw_mgmt_event,     // Bandwidth management event.
   input wire logic auto_bw_event,     // Autonomous bandwidth event.
   input wire logic slot_clk_load,     // Loader writes the slot clock default.
   input wire logic slot_clk_value,    // Value written by the loader.
   input wire logic l0s_exit_req,      // Transmitter leaves L0s.
   input wire logic l1_exit_req,       // Transmitter leaves L1.
   input wire logic os_ready,          // Transmitter takes an ordered set.
   output logic os_valid,              // Ordered set requested.
   output logic os_is_ts1,             // One for TS1, zero for FTS.
   output logic exit_done,             // Exit sequence finished.
   input wire logic clk_idle,          // Link may give up its reference clock.
   input wire logic clkreq_n_in,       // Clock request pin level.
   output logic clkreq_n_out,          // Clock request pin drive value.
   output logic clkreq_n_oe,           // Clock request pin drive enable.
   output logic link_clk_removable,    // Reference clock may be stopped.
   output logic l0s_entry_en,          // Transmit L0s entry allowed.
   output logic l1_entry_en,           // L1 entry allowed.
   output logic rx_l0s_en,             // Receive L0s entry allowed.
   output logic link_disable,          // Link held disabled.
   output logic retrain_pulse,         // One-cycle retrain start.
   output logic common_clk,            // Shared reference clock in use.
   output logic hw_width_dis,          // Autonomous width change disabled.
   output logic bw_mgmt_int_en,        // Bandwidth management interrupt enable.
   output logic auto_bw_int_en         // Autonomous bandwidth interrupt enable.
);

   // ==========================================================================
   // Helpers
   // ==========================================================================
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic bit_written(input logic [31:0] mask, input logic [31:0] data, input int pos);
      bit_written = mask[pos] & data[pos];
   endfunction

   // ==========================================================================
   // Access decode
   // ==========================================================================
   logic hit;
   logic wr_hit;
   logic [31:0] wmask;

   assign hit = cfg_req && (cfg_addr[11:2] == LINK_REG_OFFSET[11:2]);
   assign wr_hit = hit && cfg_wr;
   assign wmask = wr_hit ? lane_mask(cfg_be) : 32'h0000_0000;

   // ==========================================================================
   // Control half
   // ==========================================================================
   logic [1:0] aspm, next_aspm;
   logic dis, next_dis;
   logic retrain, next_retrain;
   logic cclk, next_cclk;
   logic ext_sync, next_ext_sync;
   logic clk_pm, next_clk_pm;
   logic width_dis, next_width_dis;
   logic bw_ie, next_bw_ie;
   logic abw_ie, next_abw_ie;

   always_comb begin
      next_aspm = aspm;
      next_dis = dis;
      next_cclk = cclk;
      next_ext_sync = ext_sync;
      next_clk_pm = clk_pm;
      next_width_dis = width_dis;
      next_bw_ie = bw_ie;
      next_abw_ie = abw_ie;
      next_retrain = 1'b0;
      if (wmask[ASPM_LSB]) begin
         next_aspm = cfg_wdata[ASPM_LSB +: 2]; // [R01]
      end
      if (wmask[COMMON_CLK_BIT]) begin
         next_cclk = cfg_wdata[COMMON_CLK_BIT]; // [R06]
      end
      if (wmask[EXT_SYNC_BIT]) begin
         next_ext_sync = cfg_wdata[EXT_SYNC_BIT]; // [R07]
      end
      if (wmask[HW_WIDTH_DIS_BIT]) begin
         next_width_dis = cfg_wdata[HW_WIDTH_DIS_BIT];
      end
      if (UPSTREAM_PORT) begin
         next_dis = 1'b0; // [R04]
         next_bw_ie = 1'b0; // [R09]
         next_abw_ie = 1'b0; // [R09]
         if (wmask[CLK_PM_BIT]) begin
            next_clk_pm = cfg_wdata[CLK_PM_BIT]; // [R08]
         end
      end else begin
         next_clk_pm = 1'b0; // [R08]
         if (wmask[LINK_DIS_BIT]) begin
            next_dis = cfg_wdata[LINK_DIS_BIT]; // [R04]
         end
         if (wmask[BW_MGMT_IE_BIT]) begin
            next_bw_ie = cfg_wdata[BW_MGMT_IE_BIT]; // [R09]
         end
         if (wmask[AUTO_BW_IE_BIT]) begin
            next_abw_ie = cfg_wdata[AUTO_BW_IE_BIT]; // [R09]
         end
         next_retrain = bit_written(wmask, cfg_wdata, RETRAIN_BIT); // [R05]
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         aspm <= ASPM_RESET;
         dis <= 1'b0;
         retrain <= 1'b0;
         cclk <= 1'b0;
         ext_sync <= 1'b0;
         clk_pm <= 1'b0;
         width_dis <= 1'b0;
         bw_ie <= 1'b0;
         abw_ie <= 1'b0;
      end else begin
         aspm <= next_aspm;
         dis <= next_dis;
         retrain <= next_retrain;
         cclk <= next_cclk;
         ext_sync <= next_ext_sync;
         clk_pm <= next_clk_pm;
         width_dis <= next_width_dis;
         bw_ie <= next_bw_ie;
         abw_ie <= next_abw_ie;
      end
   end

   // ==========================================================================
   // Status half
   // ==========================================================================
   logic [3:0] speed, next_speed;
   logic [5:0] width, next_width;
   logic train_err, next_train_err;
   logic training, next_training;
   logic slot_clk, next_slot_clk;
   logic dl_up, next_dl_up;
   logic bw_st, next_bw_st;
   logic abw_st, next_abw_st;

   always_comb begin
      next_speed = speed;
      next_width = width;
      next_slot_clk = slot_clk;
      next_dl_up = dl_active; // [R15]
      next_train_err = train_err;
      next_training = training;
      if (lt_done) begin
         next_speed = neg_speed; // [R10]
         next_width = neg_width; // [R11]
         next_train_err = 1'b0; // [R12]
         next_training = 1'b0; // [R13]
      end
      // A failure or a new start in the same cycle as completion wins.
      if (lt_fail) begin
         next_train_err = 1'b1; // [R12]
      end
      if (lt_start || retrain) begin
         next_training = 1'b1; // [R13]
      end
      if (slot_clk_load) begin
         next_slot_clk = slot_clk_value; // [R14]
      end
      // Write-one-to-clear; an event in the clearing cycle keeps the bit set.
      next_bw_st = (bw_st && !bit_written(wmask, cfg_wdata, BW_MGMT_ST_BIT)) || bw_mgmt_event; // [R16]
      next_abw_st = (abw_st && !bit_written(wmask, cfg_wdata, AUTO_BW_ST_BIT)) || auto_bw_event; // [R16]
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         speed <= SPEED_RESET;
         width <= WIDTH_RESET;
         train_err <= 1'b0;
         training <= TRAINING_RESET;
         slot_clk <= SLOT_CLK_RESET;
         dl_up <= 1'b0;
         bw_st <= 1'b0;
         abw_st <= 1'b0;
      end else begin
         speed <= next_speed;
         width <= next_width;
         train_err <= next_train_err;
         training <= next_training;
         slot_clk <= next_slot_clk;
         dl_up <= next_dl_up;
         bw_st <= next_bw_st;
         abw_st <= next_abw_st;
      end
   end

   // ==========================================================================
   // Read path and answer
   // ==========================================================================
   logic [31:0] dword;
   logic [31:0] next_rdata;
   logic next_ack;

   always_comb begin
      dword = 32'h0000_0000;
      dword[ASPM_LSB +: 2] = aspm;
      dword[RCB_BIT] = 1'b0; // [R03]
      dword[LINK_DIS_BIT] = dis;
      dword[RETRAIN_BIT] = 1'b0; // [R05]
      dword[COMMON_CLK_BIT] = cclk;
      dword[EXT_SYNC_BIT] = ext_sync;
      dword[CLK_PM_BIT] = clk_pm;
      dword[HW_WIDTH_DIS_BIT] = width_dis;
      dword[BW_MGMT_IE_BIT] = bw_ie;
      dword[AUTO_BW_IE_BIT] = abw_ie;
      dword[SPEED_LSB +: 4] = speed;
      dword[WIDTH_LSB +: 6] = width;
      dword[TRAIN_ERR_BIT] = train_err;
      dword[TRAINING_BIT] = training;
      dword[SLOT_CLK_BIT] = slot_clk;
      dword[DL_ACTIVE_BIT] = dl_up;
      dword[BW_MGMT_ST_BIT] = bw_st;
      dword[AUTO_BW_ST_BIT] = abw_st;
      next_ack = cfg_req;
      // Other offsets belong to neighbouring registers; here they answer with zero.
      next_rdata = (hit && !cfg_wr) ? dword : 32'h0000_0000;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_ack <= 1'b0;
         cfg_rdata <= 32'h0000_0000;
      end else begin
         cfg_ack <= next_ack;
         cfg_rdata <= next_rdata;
      end
   end

   // ==========================================================================
   // Clock request pin
   // ==========================================================================
   logic clkreq_s1, clkreq_s2;
   logic next_oe, next_removable;

   always_comb begin
      // Disabled: drive the pin low so the reference clock keeps running.
      next_oe = !(clk_pm && clk_idle); // [R08]
      // The clock stops only once every party on the wired pin has released it.
      next_removable = clk_pm && clk_idle && clkreq_s2; // [R08]
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         clkreq_s1 <= 1'b0;
         clkreq_s2 <= 1'b0;
         clkreq_n_oe <= 1'b1;
         clkreq_n_out <= 1'b0;
         link_clk_removable <= 1'b0;
      end else begin
         clkreq_s1 <= clkreq_n_in;
         clkreq_s2 <= clkreq_s1;
         clkreq_n_oe <= next_oe;
         clkreq_n_out <= 1'b0;
         link_clk_removable <= next_removable;
      end
   end

   // ==========================================================================
   // Control outputs
   // ==========================================================================
   always_comb begin
      l0s_entry_en = (aspm == ASPM_L0S_ONLY) || (aspm == ASPM_BOTH); // [R01]
      l1_entry_en = (aspm == ASPM_L1_ONLY) || (aspm == ASPM_BOTH); // [R01]
      rx_l0s_en = 1'b1; // [R02]
      link_disable = dis;
      retrain_pulse = retrain;
      common_clk = cclk;
      hw_width_dis = width_dis;
      bw_mgmt_int_en = bw_ie;
      auto_bw_int_en = abw_ie;
   end

   // ==========================================================================
   // Exit ordered-set sequencer
   // ==========================================================================
   exit_seq_if seq_bus ();

   assign seq_bus.req = l0s_exit_req || l1_exit_req;
   assign seq_bus.from_l1 = l1_exit_req;
   assign seq_bus.ext_sync = ext_sync; // [R07]
   assign seq_bus.os_ready = os_ready;
   assign os_valid = seq_bus.os_valid;
   assign os_is_ts1 = seq_bus.os_is_ts1;
   assign exit_done = seq_bus.done;

   exit_sequencer #(
      .N_FTS(N_FTS),
      .N_TS1(N_TS1)
   ) u_exit_seq (
      .core_clk(core_clk),
      .rst(rst),
      .sq(seq_bus.seq)
   );

endmodule
`default_nettype wire

/* File: link_ctrl_status_checker.sv */
// Concurrent checks on the ports of link_ctrl_status.
// Assumes one clock, core_clk, and synchronous active-high rst.
`timescale 1ns/1ns
`default_nettype none
module link_ctrl_status_checker
   import link_regs_pkg::*;
#(parameter bit UPSTREAM_PORT = 1'b0) (
   input wire logic core_clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic cfg_req, // Request.
   input wire logic cfg_wr, // Write.
   input wire logic [11:0] cfg_addr, // Address.
   input wire logic [3:0] cfg_be, // Byte enables.
   input wire logic [31:0] cfg_wdata, // Write data.
   input wire logic cfg_ack, // Answer.
   input wire logic [31:0] cfg_rdata, // Read data.
   input wire logic l0s_exit_req, // L0s exit.
   input wire logic l1_exit_req, // L1 exit.
   input wire logic os_ready, // Set taken.
   input wire logic os_valid, // Set offered.
   input wire logic os_is_ts1, // Set kind.
   input wire logic exit_done, // Exit over.
   input wire logic clkreq_n_oe, // Pin enable.
   input wire logic rx_l0s_en, // Receive L0s.
   input wire logic retrain_pulse // Retrain start.
);
   // ====
   // Properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic rt_wr = !UPSTREAM_PORT && cfg_req && cfg_wr && cfg_addr[11:2] == LINK_REG_OFFSET[11:2]
      && cfg_be[0] && cfg_wdata[RETRAIN_BIT];
   a_ack_follows_req: assert property (cfg_ack == $past(cfg_req)) else $error("ack late");
   a_rdata_idle_zero: assert property (!cfg_ack |-> cfg_rdata == 32'h0) else $error("rdata not idle");
   a_rx_l0s_kept: assert property (rx_l0s_en) else $error("rx L0s off");
   a_retrain_starts: assert property (rt_wr |=> retrain_pulse) else $error("no retrain");
   a_retrain_cause: assert property (retrain_pulse |-> $past(rt_wr)) else $error("stray retrain");
   a_clkreq_held: assert property (!UPSTREAM_PORT |-> clkreq_n_oe) else $error("clkreq released");
   a_exit_kind: assert property ($rose(os_valid) |-> os_is_ts1 == $past(l1_exit_req)
      && $past(l0s_exit_req || l1_exit_req)) else $error("bad exit start");
   a_set_held: assert property (os_valid && !os_ready |=> os_valid && $stable(os_is_ts1))
      else $error("set dropped");
   a_done_single: assert property (exit_done |-> !os_valid ##1 !exit_done) else $error("done long");
endmodule
bind link_ctrl_status link_ctrl_status_checker #(.UPSTREAM_PORT(UPSTREAM_PORT)) u_chk (.core_clk(core_clk),
   .rst(rst), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
   .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .l0s_exit_req(l0s_exit_req), .l1_exit_req(l1_exit_req),
   .os_ready(os_ready), .os_valid(os_valid), .os_is_ts1(os_is_ts1), .exit_done(exit_done),
   .clkreq_n_oe(clkreq_n_oe), .rx_l0s_en(rx_l0s_en), .retrain_pulse(retrain_pulse));
`default_nettype wire

/* File: pcie_link_control_status_tb.sv */
// Testbench for a downstream link_ctrl_status, driving the config port and status inputs.
// Assumes the checker is bound in its own file.
`timescale 1ns/1ns
`default_nettype none
module pcie_link_control_status_tb;
   import link_regs_pkg::*;
   logic core_clk = 0, rst = 1, cfg_req = 0, cfg_wr = 0, os_ready = 1, dl_active = 0, l0s_exit_req = 0;
   logic l1_exit_req = 0, cfg_ack, os_valid, os_is_ts1, exit_done, clkreq_n_out, clkreq_n_oe, l0s_entry_en;
   logic l1_entry_en, rx_l0s_en, link_disable, retrain_pulse, common_clk, hw_width_dis, bw_ie, abw_ie, clk_rm;
   logic [11:0] cfg_addr = 0;
   logic [3:0] cfg_be = 0, neg_speed = 4'h1;
   logic [5:0] ev = 0, neg_width = 6'h04;
   logic [31:0] cfg_wdata = 0, cfg_rdata, rd;
   int n_fail = 0, check_count = 0;
   // The open-drain pin reads high unless the block pulls it.
   wire logic clkreq_pin = clkreq_n_oe ? clkreq_n_out : 1'b1;
   link_ctrl_status #(.UPSTREAM_PORT(1'b0), .N_FTS(13'h0002), .N_TS1(13'h0003)) DUT (.core_clk(core_clk),
      .rst(rst), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
      .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .lt_start(ev[0]), .lt_done(ev[1]), .lt_fail(ev[2]),
      .neg_speed(neg_speed), .neg_width(neg_width), .dl_active(dl_active), .bw_mgmt_event(ev[3]),
      .auto_bw_event(ev[4]), .slot_clk_load(ev[5]), .slot_clk_value(1'b0), .l0s_exit_req(l0s_exit_req),
      .l1_exit_req(l1_exit_req), .os_ready(os_ready), .os_valid(os_valid), .os_is_ts1(os_is_ts1),
      .exit_done(exit_done), .clk_idle(1'b1), .clkreq_n_in(clkreq_pin), .clkreq_n_out(clkreq_n_out),
      .clkreq_n_oe(clkreq_n_oe), .link_clk_removable(clk_rm), .l0s_entry_en(l0s_entry_en), .l1_entry_en(l1_entry_en),
      .rx_l0s_en(rx_l0s_en), .link_disable(link_disable), .retrain_pulse(retrain_pulse), .common_clk(common_clk),
      .hw_width_dis(hw_width_dis), .bw_mgmt_int_en(bw_ie), .auto_bw_int_en(abw_ie));
   // ====
   // Tasks
   initial forever #25 core_clk = ~core_clk;
   function automatic logic [31:0] dw(logic [5:0] f, logic [3:0] sp, logic [5:0] w, logic [15:0] c);
      return {f, w, sp, c};
   endfunction
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic acc(logic wr, logic [11:0] a, logic [3:0] be, logic [31:0] d);
      @(posedge core_clk);
      cfg_req <= 1;
      cfg_wr <= wr;
      cfg_addr <= a;
      cfg_be <= be;
      cfg_wdata <= d;
      @(posedge core_clk);
      cfg_req <= 0;
      #1;
      rd = cfg_rdata;
      check("ack", cfg_ack, 1);
   endtask
   task automatic rdchk(string nm, logic [31:0] exp);
      acc(0, LINK_REG_OFFSET, 4'h0, 0);
      check(nm, rd, exp);
   endtask
   task automatic pulse(logic [5:0] m);
      @(posedge core_clk);
      ev <= m;
      @(posedge core_clk);
      ev <= 0;
   endtask
   task automatic run_exit(logic l1, int exp);
      int n;
      n = 0;
      @(posedge core_clk);
      l0s_exit_req <= !l1;
      l1_exit_req <= l1;
      @(posedge core_clk);
      l0s_exit_req <= 0;
      l1_exit_req <= 0;
      repeat (9000) begin
         @(posedge core_clk);
         if (exit_done) break;
         if (os_valid && os_ready) n++;
         // The transmitter stalls every other cycle.
         os_ready <= !os_ready;
      end
      check("set count", n, exp);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ====
   // Tests
   initial begin
      #1500000;
      n_fail++;
      close_out;
   end
   initial begin
      repeat (6) @(posedge core_clk);
      rst <= 0;
      rdchk("reset dword", dw(6'h06, 4'h2, 6'h01, 16'h0));
      for (int i = 0; i < 4; i++) begin
         acc(1, LINK_REG_OFFSET, 4'h1, i);
         check("entry enables", {l1_entry_en, l0s_entry_en, rx_l0s_en}, {i[1:0], 1'b1});
         rdchk("aspm", dw(6'h06, 4'h2, 6'h01, i[15:0]));
      end
      $display("power-state entry test done");
      acc(1, LINK_REG_OFFSET, 4'h3, 32'hffff);
      check("retrain", retrain_pulse, 1);
      check("controls", {link_disable, common_clk, hw_width_dis, bw_ie, abw_ie}, 5'h1f);
      check("clock request", {clkreq_n_oe, clkreq_n_out, clk_rm}, 3'h4);
      rdchk("control", dw(6'h06, 4'h2, 6'h01, 16'h0ed3));
      $display("control test done");
      run_exit(1, 1024);
      run_exit(0, 4096);
      acc(1, LINK_REG_OFFSET, 4'h1, 32'h53);
      run_exit(0, 2);
      run_exit(1, 3);
      $display("exit sequence test done");
      pulse(6'h04);
      rdchk("train fail", dw(6'h07, 4'h2, 6'h01, 16'h0e53));
      pulse(6'h02);
      rdchk("trained", dw(6'h04, 4'h1, 6'h04, 16'h0e53));
      @(posedge core_clk);
      dl_active <= 1;
      pulse(6'h39);
      rdchk("events", dw(6'h3a, 4'h1, 6'h04, 16'h0e53));
      acc(1, LINK_REG_OFFSET, 4'h8, 32'h4000_0000);
      rdchk("clear bw", dw(6'h2a, 4'h1, 6'h04, 16'h0e53));
      acc(1, LINK_REG_OFFSET, 4'h8, 32'h8000_0000);
      @(posedge core_clk);
      dl_active <= 0;
      rdchk("clear abw", dw(6'h02, 4'h1, 6'h04, 16'h0e53));
      $display("status test done");
      acc(1, 12'h0d4, 4'hf, 32'hffff_ffff);
      acc(0, 12'h0d4, 4'hf, 0);
      check("unmapped", rd, 0);
      rdchk("untouched", dw(6'h02, 4'h1, 6'h04, 16'h0e53));
      $display("unmapped test done");
      close_out;
   end
endmodule
`default_nettype wire
